// ==== hdl/ovb_pkg.sv ====
// Package with register map, field layout, reset values and timing for the output gain bank.
package ovb_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [13:0] RAMP_RATE_IDX = 14'h0409;
	localparam logic [13:0] PATH2_RIGHT_IDX = 14'h041D;
	localparam logic [13:0] PATH3_IDX = 14'h0421;
	localparam logic [13:0] PATH4_LEFT_IDX = 14'h0429;
	localparam logic [13:0] PATH4_RIGHT_IDX = 14'h042D;
	localparam logic [13:0] PATH5_LEFT_IDX = 14'h0431;
	localparam logic [13:0] PATH5_RIGHT_IDX = 14'h0435;
	localparam int NUM_CHAN = 6;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int STROBE_BIT = 9;
	localparam int SILENCE_BIT = 8;
	localparam int FALL_RATE_LSB = 4;
	localparam int RISE_RATE_LSB = 0;
	localparam logic [7:0] GAIN_CODE_RST = 8'h80;
	localparam logic SILENCE_RST = 1'b1;
	localparam logic [2:0] RAMP_RATE_RST = 3'h2;
	localparam logic [7:0] GAIN_CODE_MAX = 8'hBF;
	// ----------------------------------------------------------------
	// Timing: internal level moves in 0.125dB steps, 48 steps per 6dB
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int HALF_MS_NS = 500000;
	localparam int STEPS_PER_6DB = 48;
	localparam int STEP_BASE_CYC = (HALF_MS_NS / CLK_PERIOD_NS) / STEPS_PER_6DB;
	localparam int LEVEL_W = 10;
	localparam int CNT_W = 16;

	typedef struct packed {
		logic silence;
		logic [7:0] code;
	} ovb_chan_cfg_t;

	typedef struct packed {
		logic [2:0] fall;
		logic [2:0] rise;
	} ovb_ramp_cfg_t;
endpackage

// ==== hdl/ovb_bank.sv ====
// Output path gain and silence register bank with staged update and gain ramping.
//
// Overview of operation
// RQ1: Writing one to the apply strobe loads all staged channel settings together.
// RQ2: Bit 8 of each channel silences it when one; resets to silenced.
// RQ3: Gain code bits 7:0 step 0.5dB; 00h is -64dB, BFh is +31.5dB.
// RQ4: Software must not write gain codes C0h to FFh; they are reserved.
// RQ5: Gain codes reset to 80h, meaning 0dB.
// RQ6: Path 3 is one mono channel; paths 4 and 5 have left and right.
// RQ7: Writes without the strobe only stage values; active gain stays unchanged.
// RQ8: Gain ramps; rises use the rising rate, falls the falling rate.
// RQ9: Software avoids strobe soon after path enable and rate changes mid-ramp.
// RQ10: The strobe bit is a pulse, stores nothing and reads back zero.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module ovb_bank #(
	parameter int STEP_BASE = ovb_pkg::STEP_BASE_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [ovb_pkg::NUM_CHAN*ovb_pkg::LEVEL_W-1:0] gain_level,
	output logic [ovb_pkg::NUM_CHAN-1:0] silenced,
	output logic ramp_busy
);
	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Returns the channel slot of a word index, or NUM_CHAN when not a channel.
	function automatic logic [2:0] chan_of(input logic [13:0] idx);
		logic [2:0] c;
		c = 3'h6;
		unique case (idx)
			ovb_pkg::PATH2_RIGHT_IDX: c = 3'h0;
			ovb_pkg::PATH3_IDX: c = 3'h1;
			ovb_pkg::PATH4_LEFT_IDX: c = 3'h2;
			ovb_pkg::PATH4_RIGHT_IDX: c = 3'h3;
			ovb_pkg::PATH5_LEFT_IDX: c = 3'h4;
			ovb_pkg::PATH5_RIGHT_IDX: c = 3'h5;
			default: c = 3'h6;
		endcase
		return c;
	endfunction

	// Rate code to ramp time per 6dB in half-millisecond units.
	function automatic logic [6:0] rate_units(input logic [2:0] r);
		logic [6:0] u;
		u = 7'h00;
		unique case (r)
			3'h0: u = 7'h00;
			3'h1: u = 7'h01;
			3'h2: u = 7'h02;
			3'h3: u = 7'h04;
			3'h4: u = 7'h08;
			3'h5: u = 7'h10;
			3'h6: u = 7'h1E;
			3'h7: u = 7'h3C;
		endcase
		return u;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [13:0] word_idx;
	logic [2:0] sel_chan;
	logic is_ramp;
	logic mapped;
	logic wr_access;
	logic apply_pulse;
	assign word_idx = paddr[15:2];
	assign sel_chan = chan_of(word_idx);
	assign is_ramp = (word_idx == ovb_pkg::RAMP_RATE_IDX);
	assign mapped = (sel_chan != 3'h6) || is_ramp;
	assign wr_access = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign apply_pulse = wr_access && (sel_chan != 3'h6) && pwdata[ovb_pkg::STROBE_BIT]; // RQ1 RQ10

	// ----------------------------------------------------------------
	// Staged settings and ramp rates
	// ----------------------------------------------------------------
	ovb_pkg::ovb_chan_cfg_t stage_reg [ovb_pkg::NUM_CHAN];
	ovb_pkg::ovb_chan_cfg_t stage_next [ovb_pkg::NUM_CHAN];
	ovb_pkg::ovb_chan_cfg_t act_reg [ovb_pkg::NUM_CHAN];
	ovb_pkg::ovb_ramp_cfg_t ramp_reg;

	always_comb
	begin
		for (int i = 0; i < ovb_pkg::NUM_CHAN; i++)
		begin
			stage_next[i] = stage_reg[i];
			if (wr_access && sel_chan == 3'(i))
			begin
				stage_next[i].silence = pwdata[ovb_pkg::SILENCE_BIT]; // RQ2 RQ6
				stage_next[i].code = pwdata[7:0]; // RQ3
			end
		end
	end

	always_ff @(posedge clk)
	begin
		for (int i = 0; i < ovb_pkg::NUM_CHAN; i++)
		begin
			if (!nrst)
			begin
				stage_reg[i].silence <= ovb_pkg::SILENCE_RST; // RQ2
				stage_reg[i].code <= ovb_pkg::GAIN_CODE_RST; // RQ5
			end
			else
			begin
				stage_reg[i] <= stage_next[i]; // RQ7
			end
		end
	end

	// The strobe in the same write also carries that write's own new value.
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < ovb_pkg::NUM_CHAN; i++)
		begin
			if (!nrst)
			begin
				act_reg[i].silence <= ovb_pkg::SILENCE_RST; // RQ2
				act_reg[i].code <= ovb_pkg::GAIN_CODE_RST; // RQ5
			end
			else if (apply_pulse)
			begin
				act_reg[i] <= stage_next[i]; // RQ1
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ramp_reg.fall <= ovb_pkg::RAMP_RATE_RST;
			ramp_reg.rise <= ovb_pkg::RAMP_RATE_RST;
		end
		else if (wr_access && is_ramp)
		begin
			ramp_reg.fall <= pwdata[ovb_pkg::FALL_RATE_LSB +: 3];
			ramp_reg.rise <= pwdata[ovb_pkg::RISE_RATE_LSB +: 3];
		end
	end

	// Read data is captured in the setup phase so the access phase sees a flop.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (psel && !penable && !pwrite)
		begin
			prdata <= 32'h0000_0000;
			if (is_ramp)
			begin
				prdata[ovb_pkg::FALL_RATE_LSB +: 3] <= ramp_reg.fall;
				prdata[ovb_pkg::RISE_RATE_LSB +: 3] <= ramp_reg.rise;
			end
			else if (sel_chan != 3'h6)
			begin
				prdata[8:0] <= stage_reg[sel_chan]; // RQ10
			end
		end
	end

	// ----------------------------------------------------------------
	// Gain ramp per channel
	// ----------------------------------------------------------------
	// Level is in 0.125dB steps: 0 is -64dB, 512 is 0dB; silence aims at 0.
	logic [ovb_pkg::LEVEL_W-1:0] level_reg [ovb_pkg::NUM_CHAN];
	logic [ovb_pkg::LEVEL_W-1:0] target [ovb_pkg::NUM_CHAN];
	logic [ovb_pkg::CNT_W-1:0] cnt_reg [ovb_pkg::NUM_CHAN];
	logic [ovb_pkg::CNT_W-1:0] interval [ovb_pkg::NUM_CHAN];
	logic [ovb_pkg::NUM_CHAN-1:0] moving;

	always_comb
	begin
		for (int i = 0; i < ovb_pkg::NUM_CHAN; i++)
		begin
			target[i] = act_reg[i].silence ? '0 : {act_reg[i].code, 2'b00}; // RQ2 RQ3
			moving[i] = (level_reg[i] != target[i]);
			interval[i] = ovb_pkg::CNT_W'(
				rate_units((target[i] > level_reg[i]) ? ramp_reg.rise : ramp_reg.fall)
				* STEP_BASE); // RQ8
		end
	end

	always_ff @(posedge clk)
	begin
		for (int i = 0; i < ovb_pkg::NUM_CHAN; i++)
		begin
			if (!nrst)
			begin
				level_reg[i] <= '0;
				cnt_reg[i] <= '0;
			end
			else if (!moving[i])
			begin
				cnt_reg[i] <= '0;
			end
			else if (interval[i] == '0)
			begin
				level_reg[i] <= target[i]; // RQ8
			end
			else if (cnt_reg[i] >= interval[i] - 1'b1)
			begin
				cnt_reg[i] <= '0;
				if (target[i] > level_reg[i])
					level_reg[i] <= level_reg[i] + 1'b1; // RQ8
				else
					level_reg[i] <= level_reg[i] - 1'b1; // RQ8
			end
			else
			begin
				cnt_reg[i] <= cnt_reg[i] + 1'b1;
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < ovb_pkg::NUM_CHAN; i++)
		begin
			gain_level[i*ovb_pkg::LEVEL_W +: ovb_pkg::LEVEL_W] = level_reg[i];
			silenced[i] = act_reg[i].silence && !moving[i];
		end
		ramp_busy = |moving;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_apply_loads;
		@(posedge clk) disable iff (!nrst)
		apply_pulse |=> (act_reg[3] == stage_reg[3]) && (act_reg[0] == stage_reg[0]);
	endproperty
	a_apply_loads: assert property (p_apply_loads) else $error("strobe did not load"); // RQ1

	property p_hold_without_strobe;
		@(posedge clk) disable iff (!nrst)
		!apply_pulse |=> $stable(act_reg[2]) && $stable(act_reg[5]);
	endproperty
	a_hold_without_strobe: assert property (p_hold_without_strobe) else $error("active moved"); // RQ7

	property p_reset_values;
		@(posedge clk)
		!nrst |=> stage_reg[1] == 9'h180 && act_reg[4] == 9'h180 && level_reg[4] == '0;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("bad reset value"); // RQ2

	property p_reset_gain;
		@(posedge clk)
		!nrst |=> act_reg[0].code == 8'h80 && stage_reg[5].code == 8'h80;
	endproperty
	a_reset_gain: assert property (p_reset_gain) else $error("gain code not 80h"); // RQ5

	property p_strobe_reads_zero;
		@(posedge clk) disable iff (!nrst)
		psel && penable && !pwrite |-> prdata[31:9] == '0;
	endproperty
	a_strobe_reads_zero: assert property (p_strobe_reads_zero) else $error("strobe read 1"); // RQ10

	property p_target_map;
		@(posedge clk) disable iff (!nrst)
		!act_reg[3].silence |-> target[3] == 10'(act_reg[3].code) * 4;
	endproperty
	a_target_map: assert property (p_target_map) else $error("code map wrong"); // RQ3

	property p_side_independent;
		@(posedge clk) disable iff (!nrst)
		wr_access && sel_chan == 3'h2 |=> $stable(stage_reg[3]) && $stable(stage_reg[1]);
	endproperty
	a_side_independent: assert property (p_side_independent) else $error("write leaked"); // RQ6

	property p_rise_paced;
		@(posedge clk) disable iff (!nrst)
		moving[1] && ramp_reg.rise == 3'h1 && target[1] > level_reg[1] && !apply_pulse
		&& cnt_reg[1] == '0 |=> $stable(level_reg[1]);
	endproperty
	a_rise_paced: assert property (p_rise_paced) else $error("ramp stepped early"); // RQ8

	property p_fast_jump;
		@(posedge clk) disable iff (!nrst)
		moving[1] && interval[1] == '0 && !apply_pulse |=> level_reg[1] == $past(target[1]);
	endproperty
	a_fast_jump: assert property (p_fast_jump) else $error("zero rate not immediate"); // RQ8
	c_apply: cover property (@(posedge clk) disable iff (!nrst) apply_pulse);
	c_ramp_done: cover property (@(posedge clk) disable iff (!nrst) $fell(ramp_busy));
	c_unsilence: cover property (@(posedge clk) disable iff (!nrst) $fell(silenced[1]));
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench for the output gain bank.
`timescale 1ns/10ps
module tb;
	typedef struct packed
	{
		logic [2:0] ch;
		logic [31:0] d;
	} ovb_row_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [ovb_pkg::NUM_CHAN*ovb_pkg::LEVEL_W-1:0] gain_level;
	logic [ovb_pkg::NUM_CHAN-1:0] silenced;
	logic ramp_busy;
	int failures = 0;
	int compares = 0;
	logic [31:0] rd;
	logic err;
	int n;
	logic [13:0] idx_tab [6] = '{ovb_pkg::PATH2_RIGHT_IDX, ovb_pkg::PATH3_IDX,
		ovb_pkg::PATH4_LEFT_IDX, ovb_pkg::PATH4_RIGHT_IDX, ovb_pkg::PATH5_LEFT_IDX,
		ovb_pkg::PATH5_RIGHT_IDX};
	// Boundary codes, and mixed silence bits so that no channel copies its neighbour.
	ovb_row_t rows [6] = '{'{3'h0, 32'h0000_0000}, '{3'h1, 32'h0000_00BF},
		'{3'h2, 32'h0000_0180}, '{3'h3, 32'h0000_0001}, '{3'h4, 32'h0000_0040},
		'{3'h5, 32'h0000_01BE}};
	localparam logic [15:0] RAMP_ADDR = {ovb_pkg::RAMP_RATE_IDX, 2'b00};

	ovb_bank #(.STEP_BASE(2)) dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gain_level(gain_level), .silenced(silenced), .ramp_busy(ramp_busy));

	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic conclude;
		begin
			$display("checks %0d mismatches %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		begin
			compares++;
			if (seen !== exp)
			begin
				failures++;
				$display("BAD %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask

	// One transfer, then one idle edge so no signal is driven twice in a time step.
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			k = 0;
			do
			begin
				@(posedge clk);
				k++;
			end
			while (pready !== 1'b1 && k < 20);
			if (k >= 20)
			begin
				failures++;
				conclude();
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask

	function automatic logic [31:0] lvl(input int c);
		return 32'(gain_level[c*ovb_pkg::LEVEL_W+:ovb_pkg::LEVEL_W]);
	endfunction

	task automatic check_reset;
		begin
			for (int c = 0; c < 6; c++)
			begin
				apb(1'b0, {idx_tab[c], 2'b00}, 32'h0);
				chk("reset chan", rd, 32'h0000_0180);
				chk("reset level", lvl(c), 32'h0);
			end
			apb(1'b0, RAMP_ADDR, 32'h0);
			chk("reset rates", rd, 32'h0000_0022);
			chk("reset silenced", 32'(silenced), 32'h0000_003F);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		check_reset();
		$display("reset test done");
		apb(1'b1, RAMP_ADDR, 32'h0000_0000);
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, {idx_tab[rows[i].ch], 2'b00}, rows[i].d);
			apb(1'b0, {idx_tab[rows[i].ch], 2'b00}, 32'h0);
			chk("staged", rd, rows[i].d & 32'h0000_01FF);
			chk("not applied", lvl(rows[i].ch), 32'h0);
		end
		// The strobe rides on a channel write and must reload every channel at once.
		apb(1'b1, {idx_tab[0], 2'b00}, rows[0].d | 32'h0000_0200);
		apb(1'b0, {idx_tab[0], 2'b00}, 32'h0);
		chk("strobe reads zero", rd, rows[0].d);
		for (int i = 0; i < 6; i++)
		begin
			chk("applied level", lvl(rows[i].ch), rows[i].d[8] ? 32'h0 :
				{22'h0, rows[i].d[7:0], 2'b00});
			chk("silenced", 32'(silenced[rows[i].ch]), 32'(rows[i].d[8]));
		end
		$display("row test done");
		// Instant fall, then slow rise: the rate field used reveals the direction.
		// Rates are changed only while every channel is at rest.
		apb(1'b1, RAMP_ADDR, 32'h0000_0001);
		apb(1'b0, RAMP_ADDR, 32'h0);
		chk("rates", rd, 32'h0000_0001);
		apb(1'b1, {idx_tab[1], 2'b00}, 32'h0000_0240);
		@(posedge clk);
		chk("fast fall", lvl(1), 32'h0000_0100);
		apb(1'b1, {idx_tab[1], 2'b00}, 32'h0000_0283);
		chk("ramping", 32'(ramp_busy), 32'h1);
		n = 0;
		while (ramp_busy === 1'b1 && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
		// 268 steps of 0.125dB, each one rate unit of two cycles long.
		chk("ramp time", 32'(n >= 534 && n <= 538), 32'h1);
		chk("ramp end", lvl(1), 32'h0000_020C);
		$display("ramp test done");
		apb(1'b0, 16'h0000, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		// A staged fall that only a wrongly taken strobe would make visible.
		apb(1'b1, {idx_tab[1], 2'b00}, 32'h0000_0040);
		apb(1'b1, 16'h0000, 32'h0000_0200);
		chk("unmapped write err", 32'(err), 32'h1);
		@(posedge clk);
		chk("level kept", lvl(1), 32'h0000_020C);
		$display("unmapped test done");
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		check_reset();
		$display("second reset test done");
		conclude();
	end
endmodule
